/* File: rtl/rnic_ctrl.sv */
// reset pin filter, interrupt-pin trap, power-down gate, startup straps
// assumes pins are asynchronous to clk_sys; cpu logic on clk_sys
// port pads see port_cfg one cycle late, after the output flops
`default_nettype none
module rnic_ctrl
  import rnic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic external_reset_input_n,
  input wire logic nmi_pin_n,
  input wire logic power_down_instruction,
  input wire logic wake_req,
  input wire rnic_port_cfg_t port_cfg,
  input wire logic [PORT_W-1:0] port_in,
  output logic [PORT_W-1:0] port_out,
  output logic [PORT_W-1:0] port_oe,
  output logic [PORT_W-1:0] port_pin_data,
  output logic chip_reset,
  output logic nmi_trap,
  output logic power_down,
  output logic startup_config_pin_a,
  output logic startup_config_pin_b
);
  logic [1:0] rst_sync_reg;
  logic [1:0] nmi_sync_reg;
  logic [PORT_W-1:0] pin_s1_reg;
  logic [PORT_W-1:0] pin_s2_reg;
  logic nmi_prev_reg;
  logic [FILT_W-1:0] low_cnt_reg;
  logic filt_low_reg;
  logic nmi_trap_reg;
  logic [1:0] cfg_reg;
  rnic_state_t state_reg;
  rnic_state_t state_next;
  logic rst_raw;

  // two-stage synchronisers
  // reset and interrupt syncs preset high: releasing sys_rst never looks like a pin edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_sync_reg <= 2'h3;
      nmi_sync_reg <= 2'h3;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], external_reset_input_n};
      nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin_n};
      pin_s1_reg <= port_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end
  assign rst_raw = rst_sync_reg[1];

  // low must persist PASS_CYC samples; one 8 ns glitch never counts
  // lows between the two windows may go either way
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      low_cnt_reg <= '0;
      filt_low_reg <= 1'b0;
    end else if (rst_raw) begin
      low_cnt_reg <= '0;
      filt_low_reg <= 1'b0;
    end else if (low_cnt_reg < FILT_W'(FILT_CYC)) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end else begin
      filt_low_reg <= 1'b1;
    end
  end

  // falling edge on the synchronised level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi_prev_reg <= 1'b1;
      nmi_trap_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_sync_reg[1];
      nmi_trap_reg <= nmi_prev_reg & ~nmi_sync_reg[1] &
        (state_reg == RNIC_RUN);
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RNIC_RUN: begin
        // interrupt pin low lets power-down through
        if (power_down_instruction && !nmi_sync_reg[1])
          state_next = RNIC_POWER_DOWN;
      end
      RNIC_POWER_DOWN: begin
        if (wake_req)
          state_next = RNIC_RUN;
      end
      RNIC_RESET: begin
        if (!filt_low_reg)
          state_next = RNIC_RUN;
      end
      default: state_next = RNIC_RESET;
    endcase
    // filtered low reset wins from any state
    if (filt_low_reg)
      state_next = RNIC_RESET;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      state_reg <= RNIC_RESET;
    else
      state_reg <= state_next;
  end

  // straps caught on the release edge; the source keeps them steady
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      cfg_reg <= CFG_RESET;
    else if (state_reg == RNIC_RESET && state_next == RNIC_RUN)
      cfg_reg <= {pin_s2_reg[CFG_B_BIT], pin_s2_reg[CFG_A_BIT]};
  end

  // push-pull drives both levels, open drain only drives low
  // registered so the pads never see a decode glitch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port_out <= '0;
      port_oe <= '0;
    end else begin
      port_out <= port_cfg.data;
      port_oe <= port_cfg.out_en &
        (~port_cfg.open_drain | ~port_cfg.data);
    end
  end

  assign port_pin_data = pin_s2_reg;
  assign chip_reset = (state_reg == RNIC_RESET);
  assign power_down = (state_reg == RNIC_POWER_DOWN);
  assign nmi_trap = nmi_trap_reg;
  assign startup_config_pin_a = cfg_reg[0];
  assign startup_config_pin_b = cfg_reg[1];

  // a filtered low always lands in reset
  reset_entry_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    filt_low_reg |=> chip_reset) else $error("reset not entered");

  // a 1-cycle low spike never resets
  spike_reject_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rst_raw ##1 !rst_raw ##1 rst_raw |-> !filt_low_reg)
    else $error("spike passed filter");
  // low held past the count passes
  long_pass_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (!rst_raw)[*8] ##1 (!rst_raw)[*6] |-> filt_low_reg)
    else $error("long low not passed");
  filt_clear_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rst_raw |=> !filt_low_reg) else $error("filter held over high");

  trap_edge_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    nmi_trap |-> $past(nmi_prev_reg) && !$past(nmi_sync_reg[1]))
    else $error("trap without edge");
  trap_fire_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    nmi_prev_reg && !nmi_sync_reg[1] && state_reg == RNIC_RUN
    |=> nmi_trap) else $error("edge without trap");
  trap_pulse_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    nmi_trap |=> !nmi_trap) else $error("trap longer than one cycle");
  trap_gate_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    nmi_trap |-> !$past(chip_reset) && !$past(power_down))
    else $error("trap outside run");

  pd_enter_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    state_reg == RNIC_RUN && power_down_instruction && !nmi_sync_reg[1]
    && !filt_low_reg |=> power_down)
    else $error("power-down not entered");
  pd_ignore_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    state_reg == RNIC_RUN && power_down_instruction && nmi_sync_reg[1]
    |=> !power_down) else $error("power-down not ignored");

  strap_sample_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    chip_reset ##1 !chip_reset |-> startup_config_pin_a ==
    $past(pin_s2_reg[CFG_A_BIT])) else $error("strap a wrong");
  strap_b_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    chip_reset ##1 !chip_reset |-> startup_config_pin_b ==
    $past(pin_s2_reg[CFG_B_BIT])) else $error("strap b wrong");

  od_drive_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (port_oe & port_out & $past(port_cfg.open_drain)) == '0)
    else $error("open drain drove high");
  pp_drive_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ($past(port_cfg.out_en) & ~$past(port_cfg.open_drain) & ~port_oe)
    == '0) else $error("push-pull pin not driven");

  sync_delay_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    nmi_sync_reg[1] == $past(nmi_pin_n, 2)) else $error("sync depth");
  rst_sync_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rst_raw == $past(external_reset_input_n, 2))
    else $error("reset sync depth");

  // main scenarios
  cov_reset_c: cover property (@(posedge clk_sys) chip_reset ##1 !chip_reset);
  cov_trap_c: cover property (@(posedge clk_sys) nmi_trap);
  cov_pd_c: cover property (@(posedge clk_sys) !power_down ##1 power_down);
  cov_spike_c: cover property (@(posedge clk_sys)
    rst_raw ##1 !rst_raw ##1 rst_raw);
  cov_pd_block_c: cover property (@(posedge clk_sys)
    state_reg == RNIC_RUN && power_down_instruction && nmi_sync_reg[1]);
endmodule
`default_nettype wire

/* File: rtl/rnic_pkg.sv */
// package for the reset and interrupt-input control block
// assumes a single 125 MHz system clock
`default_nettype none
package rnic_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // spike filter windows, in ns
  localparam int SPIKE_REJECT_NS = 10;
  localparam int SPIKE_PASS_NS = 100;
  // longest reject rounds down, least pass rounds up
  localparam int REJECT_CYC = (SPIKE_REJECT_NS / CLK_PERIOD_NS) < 1 ? 1 :
    SPIKE_REJECT_NS / CLK_PERIOD_NS;
  localparam int PASS_CYC =
    (SPIKE_PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // filter needs one more consecutive low sample than this
  localparam int FILT_CYC = PASS_CYC - 1;
  localparam int FILT_W = 4;
  localparam int PORT_W = 6;
  localparam int CFG_A_BIT = 4;
  localparam int CFG_B_BIT = 5;
  localparam logic [1:0] CFG_RESET = 2'h0;

  typedef enum logic [1:0] {
    RNIC_RUN = 2'b00,
    RNIC_RESET = 2'b01,
    RNIC_POWER_DOWN = 2'b10
  } rnic_state_t;

  // per-pin driver setup
  typedef struct packed {
    logic [PORT_W-1:0] out_en;
    logic [PORT_W-1:0] open_drain;
    logic [PORT_W-1:0] data;
  } rnic_port_cfg_t;
endpackage
`default_nettype wire

/* File: testbench/reset_and_nmi_input_control_test.sv */
// bench for the reset, interrupt-pin and strap control block
// assumes rnic_board supplies the pins; one 125 MHz clock
`default_nettype none
module reset_and_nmi_input_control_test;
  import rnic_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic pd_ins = 1'b0;
  logic wake_req = 1'b0;
  rnic_port_cfg_t port_cfg = '0;
  logic [5:0] port_in, port_out, port_oe, pin_data;
  logic chip_reset, nmi_trap, power_down, cfg_a, cfg_b;
  int n_fail = 0;
  int comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  rnic_board rnic_board_i();
  // driven pins win, open pins follow the board
  assign port_in = (port_oe & port_out) | (~port_oe & rnic_board_i.strap);
  rnic_ctrl rnic_ctrl_i(.clk_sys(clk_sys), .sys_rst(sys_rst),
    .external_reset_input_n(rnic_board_i.rst_n),
    .nmi_pin_n(rnic_board_i.nmi_n), .power_down_instruction(pd_ins),
    .wake_req(wake_req), .port_cfg(port_cfg), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .port_pin_data(pin_data),
    .chip_reset(chip_reset), .nmi_trap(nmi_trap),
    .power_down(power_down), .startup_config_pin_a(cfg_a),
    .startup_config_pin_b(cfg_b));
  task automatic cmp(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: bit got %b want %b", $time, g, e);
    end
  endtask
  task automatic cmpv(input logic [5:0] g, input logic [5:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: port got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic pulse_pd();
    @(posedge clk_sys) pd_ins <= 1'b1;
    @(posedge clk_sys) pd_ins <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    int hits;
    hits = 0;
    // a 9 ns spike is seen by two clock samples at most
    fork
      rnic_board_i.reset_pulse(9, 2'h0);
    join_none
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      if (chip_reset !== 1'b0) hits++;
    end
    cmp(hits == 0, 1'b1);
    fork
      rnic_board_i.reset_pulse(116, 2'h2);
    join_none
    for (int i = 0; i < 40 && chip_reset !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp(chip_reset, 1'b1);
    for (int i = 0; i < 30 && chip_reset !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp(chip_reset, 1'b0);
    cmp(cfg_a, 1'b0);
    cmp(cfg_b, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_nmi_pd();
    int k;
    k = 0;
    rnic_board_i.nmi_n = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (nmi_trap === 1'b1) k++;
    end
    cmp(k == 1, 1'b1);
    pulse_pd();
    cmp(power_down, 1'b1);
    @(posedge clk_sys) wake_req <= 1'b1;
    @(posedge clk_sys) wake_req <= 1'b0;
    #1;
    cmp(power_down, 1'b0);
    rnic_board_i.nmi_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    pulse_pd();
    repeat (2) @(posedge clk_sys);
    #1;
    cmp(power_down, 1'b0);
    $display("test interrupt and power-down done");
  endtask
  task automatic t_port();
    @(posedge clk_sys) port_cfg <= '{6'h0F, 6'h0C, 6'h05};
    repeat (5) @(posedge clk_sys);
    #1;
    cmpv(port_out, 6'h05);
    cmpv(port_oe, 6'h0B);
    cmpv(pin_data, 6'h25);
    $display("test port done");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    t_reset();
    t_nmi_pd();
    t_port();
    close_out();
  end
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire

/* File: testbench/rnic_board.sv */
// board-side model: reset source, interrupt source, strap pins
// assumes the bench calls its tasks from one process at a time
`default_nettype none
module rnic_board;
  timeunit 1ns;
  timeprecision 100ps;
  logic rst_n = 1'b1;
  logic nmi_n = 1'b1;
  // undriven port pins pulled high
  logic [5:0] strap = 6'h3F;
  task automatic reset_pulse(input int ns, input logic [1:0] cfg);
    strap[5:4] = cfg;
    // off the clock edge so no sample races the pin change
    #(41);
    rst_n = 1'b0;
    #(ns);
    rst_n = 1'b1;
  endtask
endmodule
`default_nettype wire
